// ===== hdl/dsw_bus_if.sv
// Interface: data-space bus between processor core end and mapper end
`default_nettype none
interface dsw_bus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic rd;
   logic wr;
   logic [7:0] rdata;
   logic ack;
   modport core (output addr, output wdata, output rd, output wr, input rdata, input ack);
   modport mapper (input addr, input wdata, input rd, input wr, output rdata, output ack);
endinterface : dsw_bus_if
`default_nettype wire

// ===== hdl/dsw_core.sv
// Core end: APB-controlled issuer of data-space reads and writes
`default_nettype none
module dsw_core
   import dsw_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   dsw_bus_if.core bus
);
   dsw_state_t state_r, state_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic rd_r, rd_nxt;
   logic wr_r, wr_nxt;
   logic [7:0] rbyte_r, rbyte_nxt;
   logic err_r, err_nxt;
   logic base_ok_r, base_ok_nxt;
   logic bank_ok_r, bank_ok_nxt;
   logic [7:0] base_img_r, base_img_nxt;
   logic [7:0] bank_img_r, bank_img_nxt;
   logic apb_wr, cmd_go, cmd_write, bad;
   logic [7:0] cmd_addr, cmd_wdata;

   // APB decode; the slave never waits
   always_comb
   begin
      pready = 1'b1;
      pslverr = 1'b0;
      apb_wr = psel && penable && pwrite;
      cmd_addr = pwdata[DSW_CMD_ADDR_LSB +: 8];
      cmd_wdata = pwdata[DSW_CMD_WDATA_LSB +: 8];
      cmd_write = pwdata[DSW_CMD_WRITE_BIT];
      cmd_go = apb_wr && paddr == DSW_APB_CMD && state_r == DSW_IDLE;
      bad = 1'b0;
      if (!cmd_write && (cmd_addr == DSW_ADDR_WIN_BASE || cmd_addr == DSW_ADDR_BANK_SEL))
         bad = 1'b1; // [RULE_04] [RULE_07]
      if (cmd_write && cmd_addr == DSW_ADDR_BANK_SEL && $countones(cmd_wdata) > 1)
         bad = 1'b1; // [RULE_12]
      if (!cmd_write && cmd_addr[7:DSW_REGION_LSB] == DSW_REGION_WIN && !base_ok_r)
         bad = 1'b1; // [RULE_06]
      if (cmd_addr[7:DSW_REGION_LSB] == DSW_REGION_BANK && !bank_ok_r)
         bad = 1'b1; // Banked access only in 00h-3Fh after select [RULE_10] [RULE_13]
      bus.addr = addr_r;
      bus.wdata = wdata_r;
      bus.rd = rd_r;
      bus.wr = wr_r;
   end

   // APB read mux; unmapped offsets read zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         DSW_APB_STATUS:
         begin
            prdata[DSW_ST_BUSY] = state_r == DSW_WAIT;
            prdata[DSW_ST_ERR] = err_r;
            prdata[DSW_ST_BASE_OK] = base_ok_r;
            prdata[DSW_ST_BANK_OK] = bank_ok_r;
         end
         DSW_APB_RDATA: prdata[7:0] = rbyte_r;
         DSW_APB_IMAGE: prdata[15:0] = {bank_img_r, base_img_r};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // Request sequencer: one outstanding access, strobes last one cycle
   always_comb
   begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rd_nxt = 1'b0;
      wr_nxt = 1'b0;
      rbyte_nxt = rbyte_r;
      err_nxt = err_r;
      base_ok_nxt = base_ok_r;
      bank_ok_nxt = bank_ok_r;
      base_img_nxt = base_img_r;
      bank_img_nxt = bank_img_r;
      // Clear by writing one; a refusal in the same cycle wins
      if (apb_wr && paddr == DSW_APB_STATUS && pwdata[DSW_ST_ERR])
         err_nxt = 1'b0;
      unique case (state_r)
         DSW_IDLE:
            if (cmd_go && bad)
               err_nxt = 1'b1;
            else if (cmd_go)
            begin
               state_nxt = DSW_WAIT;
               addr_nxt = cmd_addr;
               wdata_nxt = cmd_wdata;
               rd_nxt = !cmd_write;
               wr_nxt = cmd_write;
               // Image updated as the write is issued, before the register changes [RULE_15]
               if (cmd_write && cmd_addr == DSW_ADDR_WIN_BASE)
               begin
                  base_img_nxt = cmd_wdata;
                  base_ok_nxt = 1'b1;
               end
               if (cmd_write && cmd_addr == DSW_ADDR_BANK_SEL)
               begin
                  bank_img_nxt = cmd_wdata;
                  bank_ok_nxt = 1'b1;
               end
            end
         DSW_WAIT:
            if (bus.ack)
            begin
               state_nxt = DSW_IDLE;
               rbyte_nxt = bus.rdata;
            end
      endcase
   end

   // Registers of the core end
   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         state_r <= DSW_IDLE;
         addr_r <= DSW_RST_BYTE;
         wdata_r <= DSW_RST_BYTE;
         rd_r <= DSW_RST_FLAG;
         wr_r <= DSW_RST_FLAG;
         rbyte_r <= DSW_RST_BYTE;
         err_r <= DSW_RST_FLAG;
         base_ok_r <= DSW_RST_FLAG;
         bank_ok_r <= DSW_RST_FLAG;
         base_img_r <= DSW_RST_BYTE;
         bank_img_r <= DSW_RST_BYTE;
      end
      else
      begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         rbyte_r <= rbyte_nxt;
         err_r <= err_nxt;
         base_ok_r <= base_ok_nxt;
         bank_ok_r <= bank_ok_nxt;
         base_img_r <= base_img_nxt;
         bank_img_r <= bank_img_nxt;
      end
   end
endmodule : dsw_core
`default_nettype wire

// ===== hdl/dsw_fix_note.sv
// Spare unit: holds no logic of its own
`default_nettype none
`default_nettype wire

// ===== hdl/dsw_mapper.sv
// Mapper end: ROM window and RAM/EEPROM bank switching in the low data space
// Operation
// RULE_01 - 40h-7Fh reads return program memory bytes
// RULE_02 - Window address: base high, six address bits low
// RULE_03 - Window moves in 64-byte steps over memory
// RULE_04 - Window base at C9h is write-only
// RULE_05 - Only base bits 5-0 stored and used
// RULE_06 - Window base not reset; write before use
// RULE_07 - Bank select at CBh, write-only
// RULE_08 - Bits 0/1 select EEPROM page 0/1
// RULE_09 - Bits 3/4 select RAM page 1/2
// RULE_10 - Banked accesses use addresses 00h-3Fh
// RULE_11 - Two RAM and two EEPROM 64-byte pages
// RULE_12 - Software sets at most one bank bit
// RULE_13 - Bank select not reset; write before use
// RULE_14 - Calls and interrupts leave bank select alone
// RULE_15 - Software keeps images, image written first
// RULE_16 - Zero or reserved pattern maps no page
`default_nettype none
module dsw_mapper
   import dsw_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   dsw_bus_if.mapper bus,
   output logic [DSW_PM_AW-1:0] pm_addr_out,
   output logic pm_rd_out,
   input wire logic [7:0] pm_data_in,
   output logic [1:0] ee_page_out,
   output logic ee_rd_out,
   output logic ee_wr_out,
   input wire logic [7:0] ee_rdata_in,
   output logic [7:0] acc_addr_out,
   output logic [7:0] acc_wdata_out,
   output logic sys_rd_out,
   output logic sys_wr_out,
   input wire logic [7:0] sys_rdata_in
);
   // Stage one holds the taken request
   logic s1_valid_r, s1_valid_nxt;
   logic s1_wr_r, s1_wr_nxt;
   logic [7:0] s1_addr_r, s1_addr_nxt;
   logic [7:0] s1_wdata_r, s1_wdata_nxt;
   // Stage two holds the answer
   logic ack_r, ack_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   // Mapping registers, deliberately without reset
   logic [DSW_BASE_W-1:0] win_base_r, win_base_nxt;
   logic [7:0] bank_sel_r, bank_sel_nxt;
   // Extra RAM pages in flip-flops
   logic [7:0] ram_r [0:1][0:DSW_PAGE_BYTES-1];
   logic [7:0] ram_nxt [0:1][0:DSW_PAGE_BYTES-1];
   // Decode
   logic win_hit, bank_hit, base_hit, bsel_hit, sys_hit;
   logic ee0_sel, ee1_sel, ram1_sel, ram2_sel, one_hot;
   logic [5:0] idx;

   // Address decode of the held request
   always_comb
   begin
      idx = s1_addr_r[5:0];
      win_hit = s1_addr_r[7:DSW_REGION_LSB] == DSW_REGION_WIN; // [RULE_01]
      bank_hit = s1_addr_r[7:DSW_REGION_LSB] == DSW_REGION_BANK; // [RULE_10]
      base_hit = s1_addr_r == DSW_ADDR_WIN_BASE;
      bsel_hit = s1_addr_r == DSW_ADDR_BANK_SEL;
      sys_hit = !win_hit && !bank_hit && !base_hit && !bsel_hit;
      // Several bits set would enable pages in parallel; map none instead
      one_hot = $onehot(bank_sel_r & DSW_BANK_USED) && ((bank_sel_r & ~DSW_BANK_USED) == DSW_READ_ZERO); // [RULE_16]
      ee0_sel = one_hot && bank_sel_r[DSW_BIT_EE0]; // [RULE_08]
      ee1_sel = one_hot && bank_sel_r[DSW_BIT_EE1]; // [RULE_08]
      ram1_sel = one_hot && bank_sel_r[DSW_BIT_RAM1]; // [RULE_09]
      ram2_sel = one_hot && bank_sel_r[DSW_BIT_RAM2]; // [RULE_09]
   end

   // Outputs toward program memory, EEPROM array and the rest of data space
   always_comb
   begin
      pm_addr_out = {1'b0, win_base_r, idx}; // [RULE_02] [RULE_03]
      pm_rd_out = s1_valid_r && !s1_wr_r && win_hit;
      ee_page_out = {ee1_sel, ee0_sel};
      ee_rd_out = s1_valid_r && !s1_wr_r && bank_hit && (ee0_sel || ee1_sel);
      ee_wr_out = s1_valid_r && s1_wr_r && bank_hit && (ee0_sel || ee1_sel); // [RULE_11]
      acc_addr_out = s1_addr_r;
      acc_wdata_out = s1_wdata_r;
      sys_rd_out = s1_valid_r && !s1_wr_r && sys_hit;
      sys_wr_out = s1_valid_r && s1_wr_r && sys_hit;
      bus.rdata = rdata_r;
      bus.ack = ack_r;
   end

   // Pipeline next state; one request taken per pulse of rd or wr
   always_comb
   begin
      s1_valid_nxt = bus.rd || bus.wr;
      s1_wr_nxt = bus.wr;
      s1_addr_nxt = bus.addr;
      s1_wdata_nxt = bus.wdata;
      ack_nxt = s1_valid_r;
      rdata_nxt = rdata_r;
      if (s1_valid_r && !s1_wr_r)
      begin
         if (win_hit)
            rdata_nxt = pm_data_in; // [RULE_01]
         else if (bank_hit && (ee0_sel || ee1_sel))
            rdata_nxt = ee_rdata_in;
         else if (bank_hit && ram1_sel)
            rdata_nxt = ram_r[0][idx]; // [RULE_11]
         else if (bank_hit && ram2_sel)
            rdata_nxt = ram_r[1][idx];
         else if (sys_hit)
            rdata_nxt = sys_rdata_in;
         else
            rdata_nxt = DSW_READ_ZERO; // Write-only registers and unmapped bank [RULE_04] [RULE_07] [RULE_16]
      end
   end

   // Mapping registers change only on a data-space write to their address
   always_comb
   begin
      win_base_nxt = win_base_r;
      bank_sel_nxt = bank_sel_r; // No save or restore on calls or interrupts [RULE_14]
      if (s1_valid_r && s1_wr_r && base_hit)
         win_base_nxt = s1_wdata_r[DSW_BASE_W-1:0]; // Bits 7-6 dropped [RULE_05]
      if (s1_valid_r && s1_wr_r && bsel_hit)
         bank_sel_nxt = s1_wdata_r & DSW_BANK_USED; // [RULE_07] [RULE_09]
   end

   // RAM page write; window region writes are simply dropped
   always_comb
   begin
      ram_nxt = ram_r;
      if (s1_valid_r && s1_wr_r && bank_hit && ram1_sel)
         ram_nxt[0][idx] = s1_wdata_r; // [RULE_10]
      if (s1_valid_r && s1_wr_r && bank_hit && ram2_sel)
         ram_nxt[1][idx] = s1_wdata_r;
   end

   // Handshake state takes reset
   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         s1_valid_r <= DSW_RST_FLAG;
         ack_r <= DSW_RST_FLAG;
         rdata_r <= DSW_RST_BYTE;
      end
      else
      begin
         s1_valid_r <= s1_valid_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Data path and mapping state; undefined until software writes it
   always_ff @(posedge ref_clk_in)
   begin
      s1_wr_r <= s1_wr_nxt;
      s1_addr_r <= s1_addr_nxt;
      s1_wdata_r <= s1_wdata_nxt;
      win_base_r <= win_base_nxt; // [RULE_06]
      bank_sel_r <= bank_sel_nxt; // [RULE_13]
      ram_r <= ram_nxt;
   end
endmodule : dsw_mapper
`default_nettype wire

// ===== hdl/dsw_pkg.sv
// Package: constants and types shared by the data-space mapper and its core end
`default_nettype none
package dsw_pkg;
   // Data-space decode
   localparam logic [7:0] DSW_ADDR_WIN_BASE = 8'hC9;
   localparam logic [7:0] DSW_ADDR_BANK_SEL = 8'hCB;
   localparam logic [1:0] DSW_REGION_BANK = 2'h0;
   localparam logic [1:0] DSW_REGION_WIN = 2'h1;
   localparam int DSW_REGION_LSB = 6;
   localparam int DSW_PAGE_BYTES = 64;
   localparam int DSW_PM_AW = 13;
   localparam int DSW_BASE_W = 6;
   // Bank select bit positions
   localparam int DSW_BIT_EE0 = 0;
   localparam int DSW_BIT_EE1 = 1;
   localparam int DSW_BIT_RAM1 = 3;
   localparam int DSW_BIT_RAM2 = 4;
   localparam logic [7:0] DSW_BANK_USED = 8'h1B;
   localparam logic [7:0] DSW_READ_ZERO = 8'h00;
   // Core-end APB register map
   localparam logic [7:0] DSW_APB_CMD = 8'h00;
   localparam logic [7:0] DSW_APB_STATUS = 8'h04;
   localparam logic [7:0] DSW_APB_RDATA = 8'h08;
   localparam logic [7:0] DSW_APB_IMAGE = 8'h0C;
   // Command word fields
   localparam int DSW_CMD_ADDR_LSB = 0;
   localparam int DSW_CMD_WDATA_LSB = 8;
   localparam int DSW_CMD_WRITE_BIT = 16;
   // Status bits
   localparam int DSW_ST_BUSY = 0;
   localparam int DSW_ST_ERR = 1;
   localparam int DSW_ST_BASE_OK = 2;
   localparam int DSW_ST_BANK_OK = 3;
   // Reset values
   localparam logic [7:0] DSW_RST_BYTE = 8'h00;
   localparam logic DSW_RST_FLAG = 1'b0;
   typedef enum logic [0:0] {DSW_IDLE, DSW_WAIT} dsw_state_t;
endpackage : dsw_pkg
`default_nettype wire

// ===== tb/data_space_window_bank_mapper_tb.sv
// Testbench: core and mapper joined, checked against a byte-level model
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); end end
module data_space_window_bank_mapper_tb
   import dsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] SEL [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, pm_rd, ee_rd, ee_wr, sys_rd, sys_wr;
   logic [12:0] pm_addr;
   logic [1:0] ee_page;
   logic [7:0] acc_addr, acc_wdata;
   logic [7:0] cyc = 8'h00;
   logic [7:0] sys_seen = 8'h00;
   logic [7:0] ee_arr [2][64];
   logic [7:0] exp_pg [4][64];
   int failures = 0;
   int comparisons = 0;
   int seed = 94155;
   // Program memory content; idle lines show a moving pattern, not stale data
   function automatic logic [7:0] pm_byte(input logic [12:0] x);
      return x[7:0] ^ {3'h0, x[12:8]};
   endfunction : pm_byte
   dsw_bus_if bus ();
   dsw_core i_dsw_core (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(bus.core));
   dsw_mapper i_dsw_mapper (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus(bus.mapper),
      .pm_addr_out(pm_addr), .pm_rd_out(pm_rd), .pm_data_in(pm_rd ? pm_byte(pm_addr) : cyc),
      .ee_page_out(ee_page), .ee_rd_out(ee_rd), .ee_wr_out(ee_wr),
      .ee_rdata_in(ee_rd ? ee_arr[ee_page[1]][acc_addr[5:0]] : cyc),
      .acc_addr_out(acc_addr), .acc_wdata_out(acc_wdata), .sys_rd_out(sys_rd),
      .sys_wr_out(sys_wr), .sys_rdata_in(sys_rd ? ~acc_addr : cyc));
   dsw_chk i_dsw_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .addr(bus.addr),
      .wdata(bus.wdata), .rd(bus.rd), .wr(bus.wr), .rdata(bus.rdata), .ack(bus.ack));
   always #2.5 ref_clk_in = ~ref_clk_in;
   // EEPROM array stand-in and idle pattern counter
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 8'h01;
      if (ee_wr)
         ee_arr[ee_page[1]][acc_addr[5:0]] <= acc_wdata;
      if (sys_wr)
         sys_seen <= acc_wdata;
   end
   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      do
         @(posedge ref_clk_in);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Issue one data-space access, wait out busy, fetch byte and refusal flag
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
      output logic e);
      logic [31:0] r;
      apb(1'b1, DSW_APB_CMD, {15'h0000, w, d, a}, r);
      do
         apb(1'b0, DSW_APB_STATUS, 32'h0000_0000, r);
      while (r[DSW_ST_BUSY] !== 1'b0);
      e = r[DSW_ST_ERR];
      apb(1'b1, DSW_APB_STATUS, 32'h0000_0002, r);
      apb(1'b0, DSW_APB_RDATA, 32'h0000_0000, r);
      q = r[7:0];
   endtask : acc
   task automatic print_verdict();
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   // Hang guard, well beyond the roughly 1100 cycles the run needs
   initial
   begin
      repeat (40000) @(posedge ref_clk_in);
      failures++;
      print_verdict();
   end
   initial
   begin
      logic [7:0] q, b, a, d;
      logic e;
      logic [31:0] r;
      int k, j;
      repeat (3) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      // Unwritten mapping registers and write-only reads are refused
      acc(1'b0, 8'h45, 8'h00, q, e);
      `CHK(e, 1'b1)
      acc(1'b0, 8'h12, 8'h00, q, e);
      `CHK(e, 1'b1)
      acc(1'b0, DSW_ADDR_WIN_BASE, 8'h00, q, e);
      `CHK(e, 1'b1)
      acc(1'b0, DSW_ADDR_BANK_SEL, 8'h00, q, e);
      `CHK(e, 1'b1)
      // Window sweep: top bits set, top step, then random bases
      for (k = 0; k < 6; k++)
      begin
         b = (k == 0) ? 8'hC0 : (k == 1) ? 8'h3F : 8'($random(seed));
         a = {2'b01, 6'($random(seed))};
         acc(1'b1, DSW_ADDR_WIN_BASE, b, q, e);
         acc(1'b1, a, 8'h5A, q, e);
         acc(1'b0, a, 8'h00, q, e);
         `CHK(q, pm_byte({1'b0, b[5:0], a[5:0]}))
      end
      acc(1'b1, DSW_ADDR_BANK_SEL, 8'h03, q, e);
      `CHK(e, 1'b1)
      // Fill all four pages at both edges of the region, then read back
      for (k = 0; k < 32; k++)
      begin
         j = k % 16;
         a = 8'(j % 4 * 21);
         if (j % 4 == 0)
            acc(1'b1, DSW_ADDR_BANK_SEL, SEL[j / 4], q, e);
         d = 8'($random(seed));
         if (k < 16)
            exp_pg[j / 4][a[5:0]] = d;
         acc(k < 16, a, d, q, e);
         if (k >= 16)
            `CHK(q, exp_pg[j / 4][a[5:0]])
      end
      // Empty and reserved selects map nothing and drop writes
      for (k = 0; k < 2; k++)
      begin
         acc(1'b1, DSW_ADDR_BANK_SEL, k == 0 ? 8'h00 : 8'h04, q, e);
         acc(1'b1, 8'h15, 8'hA5, q, e);
         acc(1'b0, 8'h15, 8'h00, q, e);
         `CHK(q, 8'h00)
      end
      acc(1'b1, DSW_ADDR_BANK_SEL, 8'h08, q, e);
      acc(1'b0, 8'h15, 8'h00, q, e);
      `CHK(q, exp_pg[2][21])
      // Other data space passes through; images follow accepted writes only
      d = 8'($random(seed));
      acc(1'b1, 8'h90, d, q, e);
      `CHK(sys_seen, d)
      acc(1'b0, 8'h90, 8'h00, q, e);
      `CHK(q, 8'h6F)
      apb(1'b0, DSW_APB_IMAGE, 32'h0000_0000, r);
      `CHK(r[15:0], {8'h08, b})
      print_verdict();
   end
endmodule : data_space_window_bank_mapper_tb
`default_nettype wire

// ===== tb/dsw_mapper_chk.sv
// Checker: data-space bus timing and core-side ordering
`default_nettype none
module dsw_chk
   import dsw_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] rdata,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic base_r, base_nxt, sel_r, sel_nxt;
   logic [7:0] bank_r, bank_nxt;
   // Seen-flags clear on reset; bank copy is left unreset like the real one
   always_comb
   begin
      base_nxt = base_r | (wr && addr == DSW_ADDR_WIN_BASE);
      sel_nxt = sel_r | (wr && addr == DSW_ADDR_BANK_SEL);
      bank_nxt = (wr && addr == DSW_ADDR_BANK_SEL) ? wdata : bank_r;
   end
   always_ff @(posedge ref_clk_in)
   begin
      base_r <= nrst_in & base_nxt;
      sel_r <= nrst_in & sel_nxt;
      bank_r <= bank_nxt;
   end
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);
   req_ack_a:
   assert property ((rd || wr) |-> !ack ##1 !ack ##1 ack)
      else $error("answer not two cycles after request");
   ack_cause_a:
   assert property (ack |-> $past(rd || wr, 2))
      else $error("answer without request");
   req_space_a:
   assert property ((rd || wr) |=> (!(rd || wr)) [*2])
      else $error("requests too close");
   rdata_hold_a:
   assert property (!(ack && $past(rd, 2)) |-> $stable(rdata))
      else $error("read byte changed without read answer");
   no_wo_read_a:
   assert property (!(rd && (addr == DSW_ADDR_WIN_BASE || addr == DSW_ADDR_BANK_SEL)))
      else $error("read of write-only register");
   bank_one_hot_a:
   assert property (wr && addr == DSW_ADDR_BANK_SEL |-> $countones(wdata) <= 1)
      else $error("several bank bits written");
   win_after_base_a:
   assert property (rd && addr[7:6] == 2'b01 |-> base_r)
      else $error("window read before base written");
   bank_after_sel_a:
   assert property ((rd || wr) && addr < 8'h40 |-> sel_r)
      else $error("bank access before select written");
   bank_none_zero_a:
   assert property (rd && addr < 8'h40 && sel_r && (bank_r & DSW_BANK_USED) == 8'h00 |-> ##2 rdata == 8'h00)
      else $error("unmapped bank read not zero");
endmodule : dsw_chk
`default_nettype wire
